// file: blit_geom_cfg.svh
/*
   offsets, field positions, widths and reset values of the blit
   geometry register bank, one `define each.
   assumes: included by bare name from the package and the modules.
*/
`ifndef BLIT_GEOM_CFG_SVH
`define BLIT_GEOM_CFG_SVH

// register port geometry
`define REG_ADDR_W        9
`define REG_DATA_W        8

// byte offsets on the register port
`define OFS_DEPTH         9'h101
`define OFS_SRC_LOW       9'h104
`define OFS_SRC_MID       9'h105
`define OFS_SRC_HIGH      9'h106
`define OFS_DEST_LOW      9'h108
`define OFS_DEST_MID      9'h109
`define OFS_DEST_HIGH     9'h10a
`define OFS_LINE_OFS_LOW  9'h10c
`define OFS_LINE_OFS_HIGH 9'h10d
`define OFS_WIDTH_LOW     9'h110
`define OFS_WIDTH_HIGH    9'h111
`define OFS_CONTROL       9'h11c
`define OFS_STATUS        9'h11e

// field widths
`define ADDR_FIELD_W      21
`define LINE_OFS_W        11
`define WIDTH_W           10

// bits used in the top byte of each multi-byte field
`define ADDR_TOP_BITS     5
`define LINE_OFS_TOP_BITS 3
`define WIDTH_TOP_BITS    2

// control, depth and status bit positions
`define CTRL_PATTERN_BIT  0
`define CTRL_RECT_BIT     1
`define DEPTH_16_BIT      0
`define STAT_NARROW_BIT   0
`define STAT_RECT_BIT     1

// reset values
`define RST_ADDR          21'h000000
`define RST_LINE_OFS      11'h000
`define RST_WIDTH         10'h000
`define RST_BYTE          8'h00

// least legal width field for a pattern fill (two pixels, minus one)
`define MIN_PATTERN_WIDTH 10'h001

`endif

// file: blit_geom_pkg.sv
/*
   types shared by the blit geometry register bank.
   assumes: blit_geom_cfg.svh sits in the same folder.
*/
`include "blit_geom_cfg.svh"

package blit_geom_pkg;

   // colour depth select, one bit
   typedef enum logic {
      depth_8  = 1'b0,
      depth_16 = 1'b1
   } pixel_depth_t;

   // whole state of the top module
   typedef struct packed {
      logic [`ADDR_FIELD_W-1:0] src;       // source start address
      logic [`ADDR_FIELD_W-1:0] dest;      // destination start address
      logic [`LINE_OFS_W-1:0]   line_ofs;  // line-to-line word offset
      logic [`WIDTH_W-1:0]      width;     // width in pixels minus one
      pixel_depth_t             depth;     // colour depth
      logic                     pattern;   // pattern fill selected
      logic                     rect;      // rectangular region selected
      logic [`REG_DATA_W-1:0]   rdata;     // read data, one cycle late
      logic [`ADDR_FIELD_W-1:0] line_addr; // current line start
      logic [`LINE_OFS_W-1:0]   eff_ofs;   // offset as applied
      logic [`ADDR_FIELD_W-1:0] pat_base;  // pattern base address
      logic [2:0]               pat_line;  // pattern line offset
      logic [3:0]               pix_ofs;   // pixel offset
      logic [`ADDR_FIELD_W-1:0] pat_sum;   // recombined source address
      logic                     narrow;    // width too small for pattern
   } bank_state_t;

endpackage

// file: reset_sync.sv
/*
   two-stage release of an asynchronous active-low reset.
   assumes: one clock; assertion may come at any time.
*/
`timescale 1ns/1ps
`default_nettype none

module reset_sync (
   input  wire logic clock,   // system clock
   input  wire logic rst_n,   // raw reset, active low
   output var  logic sync_n   // released reset, active low
);

   logic stage_n;             // first stage, read only by second

   // assert at once, release after two edges; not gated by the clock
   // enable, so the block always leaves reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage_n <= 1'b0;
         sync_n  <= 1'b0;
      end else begin
         stage_n <= 1'b1;
         sync_n  <= stage_n;
      end
   end

endmodule

`default_nettype wire

// file: pattern_split.sv
/*
   splits a source start address into pattern base, pattern line
   offset and pixel offset, and adds the three back together.
   assumes: purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
`default_nettype none
`include "blit_geom_cfg.svh"

module pattern_split
   import blit_geom_pkg::*;
(
   input  wire logic [`ADDR_FIELD_W-1:0] src,      // source start address
   input  wire pixel_depth_t             depth,    // colour depth
   output var  logic [`ADDR_FIELD_W-1:0] pat_base, // pattern base
   output var  logic [2:0]               pat_line, // pattern line offset
   output var  logic [3:0]               pix_ofs,  // pixel offset
   output var  logic [`ADDR_FIELD_W-1:0] pat_sum   // base + line + pixel
);

   // field split depends only on depth
   always_comb begin
      if (depth == depth_16) begin
         pat_base = {src[20:7], 7'h00};
         pat_line = src[6:4];
         pix_ofs  = src[3:0];
      end else begin
         pat_base = {src[20:6], 6'h00};
         pat_line = src[5:3];
         pix_ofs  = {1'b0, src[2:0]};
      end
   end

   // recombine as software must program it; line offset sits above
   // the pixel field, so the sum must give back the source address
   always_comb begin
      if (depth == depth_16) begin
         pat_sum = pat_base + {14'h0000, pat_line, pix_ofs};
      end else begin
         pat_sum = pat_base + {15'h0000, pat_line, pix_ofs[2:0]};
      end
   end

endmodule

`default_nettype wire

// file: blit_geometry_address_regs.sv
/*
   geometry and address register bank of a 2d block-transfer engine:
   destination start, line-to-line word offset, width, source start,
   colour depth and the pattern-fill split of the source address.
   assumes: a byte-wide register port on the same clock, strobes one
   cycle long and never together; the transfer datapath sits outside
   and reads the registered outputs here. line_load and line_advance
   come from that datapath on the same clock and need no sync stages;
   the reset pin may fall at any time and is released internally.
*/
`timescale 1ns/1ps
`default_nettype none
`include "blit_geom_cfg.svh"

module blit_geometry_address_regs
   import blit_geom_pkg::*;
#(
   parameter int ADDR_W = `REG_ADDR_W,  // register port address width
   parameter int DATA_W = `REG_DATA_W   // register port data width
) (
   input  wire logic                     clock,            // 250 mhz
   input  wire logic                     rst_n,            // async, low
   input  wire logic                     ce,               // clock enable
   input  wire logic [ADDR_W-1:0]        reg_addr,         // byte offset
   input  wire logic [DATA_W-1:0]        reg_wdata,        // write data
   input  wire logic                     reg_wr,           // write strobe
   input  wire logic                     reg_rd,           // read strobe
   output var  logic [DATA_W-1:0]        reg_rdata,        // read data
   input  wire logic                     line_load,        // start region
   input  wire logic                     line_advance,     // next line
   output var  logic [`ADDR_FIELD_W-1:0] dest_start_addr,  // destination
   output var  logic [`LINE_OFS_W-1:0]   line_offset,      // applied ofs
   output var  logic [`WIDTH_W-1:0]      transfer_width,   // pixels - 1
   output var  logic                     depth_16,         // 16 bpp
   output var  logic                     pattern_fill,     // pattern mode
   output var  logic                     rect_region,      // rect mode
   output var  logic [`ADDR_FIELD_W-1:0] source_start_addr,// source
   output var  logic [`ADDR_FIELD_W-1:0] pattern_base,     // pattern base
   output var  logic [2:0]               pattern_line,     // line offset
   output var  logic [3:0]               pixel_offset,     // pixel offset
   output var  logic [`ADDR_FIELD_W-1:0] pattern_src_addr, // recombined
   output var  logic [`ADDR_FIELD_W-1:0] line_addr,        // line start
   output var  logic                     width_too_narrow  // pattern < 2
);

   // working nets; every field of the bank lives in cur
   logic                     sync_n;     // reset after release stages
   bank_state_t              cur;        // registered state
   bank_state_t              next_cur;   // next state
   logic [`ADDR_FIELD_W-1:0] split_base; // split of the next source
   logic [2:0]               split_line; // split line offset
   logic [3:0]               split_pix;  // split pixel offset
   logic [`ADDR_FIELD_W-1:0] split_sum;  // split recombined
   logic [`ADDR_FIELD_W-1:0] step_addr;  // line start plus offset
   logic [DATA_W-1:0]        read_byte;  // decoded read value

   // reset release, two stages; the raw pin never reaches the state
   // register directly, so a release near an edge cannot leave some
   // fields out of reset and others still in it
   reset_sync u_reset_sync (
      .clock  (clock),
      .rst_n  (rst_n),
      .sync_n (sync_n)
   );

   // the split is pure wiring plus one adder; keeping it in its own
   // module lets the sum be checked against the source on its own
   // split works on the next source and depth, so the registered
   // split lines up with the registered source in the same cycle
   pattern_split u_pattern_split (
      .src      (next_cur.src),
      .depth    (next_cur.depth),
      .pat_base (split_base),
      .pat_line (split_line),
      .pix_ofs  (split_pix),
      .pat_sum  (split_sum)
   );

   // one line further down, in words; the offset is zero outside
   // rectangular work, so an advance there leaves the line in place
   assign step_addr = cur.line_addr
                    + {{(`ADDR_FIELD_W-`LINE_OFS_W){1'b0}}, cur.eff_ofs};

   // register map, byte offsets on the port:
   //   0x101  bit 0 colour depth, 1 = 16 bpp
   //   0x104  source start bits 7..0
   //   0x105  source start bits 15..8
   //   0x106  source start bits 20..16 in 4..0
   //   0x108  destination start bits 7..0
   //   0x109  destination start bits 15..8
   //   0x10a  destination start bits 20..16 in 4..0
   //   0x10c  line word offset bits 7..0
   //   0x10d  line word offset bits 10..8 in 2..0
   //   0x110  width bits 7..0, pixels minus one
   //   0x111  width bits 9..8 in 1..0
   //   0x11c  bit 0 pattern fill, bit 1 rectangular region
   //   0x11e  read only: bit 0 narrow width, bit 1 rectangular
   // every other offset reads zero and drops writes
   // each byte lands on its own; software sees a multi-byte field
   // change byte by byte, so it should not start a transfer midway
   // read decode; unmapped offsets and unused bits read zero.
   // the decode runs every cycle but is only latched under a read
   // strobe, so idle cycles give zero on the data port
   always_comb begin
      read_byte = '0;
      case (reg_addr)
         `OFS_DEPTH: begin
            read_byte[`DEPTH_16_BIT] = cur.depth;
         end
         `OFS_SRC_LOW: begin
            read_byte = cur.src[7:0];
         end
         `OFS_SRC_MID: begin
            read_byte = cur.src[15:8];
         end
         `OFS_SRC_HIGH: begin
            read_byte[`ADDR_TOP_BITS-1:0] = cur.src[20:16];
         end
         `OFS_DEST_LOW: begin
            read_byte = cur.dest[7:0];
         end
         `OFS_DEST_MID: begin
            read_byte = cur.dest[15:8];
         end
         `OFS_DEST_HIGH: begin
            read_byte[`ADDR_TOP_BITS-1:0] = cur.dest[20:16];
         end
         `OFS_LINE_OFS_LOW: begin
            read_byte = cur.line_ofs[7:0];
         end
         `OFS_LINE_OFS_HIGH: begin
            read_byte[`LINE_OFS_TOP_BITS-1:0] = cur.line_ofs[10:8];
         end
         `OFS_WIDTH_LOW: begin
            read_byte = cur.width[7:0];
         end
         `OFS_WIDTH_HIGH: begin
            read_byte[`WIDTH_TOP_BITS-1:0] = cur.width[9:8];
         end
         `OFS_CONTROL: begin
            read_byte[`CTRL_PATTERN_BIT] = cur.pattern;
            read_byte[`CTRL_RECT_BIT]    = cur.rect;
         end
         `OFS_STATUS: begin
            // block's own view of the programmed geometry
            read_byte[`STAT_NARROW_BIT] = cur.narrow;
            read_byte[`STAT_RECT_BIT]   = cur.rect;
         end
         default: begin
            read_byte = '0;
         end
      endcase
   end

   // all next values come from one process, so the whole bank moves
   // on one edge and every output is a flip-flop of the struct
   // next state: register writes, read data, line stepping, split
   always_comb begin
      next_cur = cur;

      // read data stands for one cycle only, zero otherwise
      next_cur.rdata = reg_rd ? read_byte : `RST_BYTE;

      // byte writes; only implemented bits are taken, the rest of
      // the byte is dropped here rather than stored and masked later
      if (reg_wr) begin
         case (reg_addr)
            `OFS_DEPTH: begin
               next_cur.depth = pixel_depth_t'(
                  reg_wdata[`DEPTH_16_BIT]);
            end
            `OFS_SRC_LOW: begin
               next_cur.src[7:0] = reg_wdata;
            end
            `OFS_SRC_MID: begin
               next_cur.src[15:8] = reg_wdata;
            end
            `OFS_SRC_HIGH: begin
               next_cur.src[20:16] = reg_wdata[`ADDR_TOP_BITS-1:0];
            end
            `OFS_DEST_LOW: begin
               next_cur.dest[7:0] = reg_wdata;
            end
            `OFS_DEST_MID: begin
               next_cur.dest[15:8] = reg_wdata;
            end
            `OFS_DEST_HIGH: begin
               // upper three bits of the byte are dropped
               next_cur.dest[20:16] =
                  reg_wdata[`ADDR_TOP_BITS-1:0];
            end
            `OFS_LINE_OFS_LOW: begin
               next_cur.line_ofs[7:0] = reg_wdata;
            end
            `OFS_LINE_OFS_HIGH: begin
               next_cur.line_ofs[10:8] =
                  reg_wdata[`LINE_OFS_TOP_BITS-1:0];
            end
            `OFS_WIDTH_LOW: begin
               next_cur.width[7:0] = reg_wdata;
            end
            `OFS_WIDTH_HIGH: begin
               next_cur.width[9:8] =
                  reg_wdata[`WIDTH_TOP_BITS-1:0];
            end
            `OFS_CONTROL: begin
               next_cur.pattern = reg_wdata[`CTRL_PATTERN_BIT];
               next_cur.rect    = reg_wdata[`CTRL_RECT_BIT];
            end
            default: begin
               // unmapped or read-only: write ignored
            end
         endcase
      end

      // offset reaches the address path only for rectangular work;
      // display refresh never sees it since it is not an output there
      next_cur.eff_ofs = next_cur.rect ? next_cur.line_ofs
                                       : `RST_LINE_OFS;

      // line stepping: load wins over advance in the same cycle, so a
      // new region never starts from a stale line start; the sum wraps
      // at 21 bits, the whole address space, and needs no check
      if (line_load) begin
         next_cur.line_addr = cur.dest;
      end else if (line_advance) begin
         next_cur.line_addr = step_addr;
      end

      // pattern split follows the source and depth being stored; fed
      // from the next values so split and source never disagree for a
      // cycle, at the cost of a longer path through the write decode
      next_cur.pat_base = split_base;
      next_cur.pat_line = split_line;
      next_cur.pix_ofs  = split_pix;
      next_cur.pat_sum  = split_sum;

      // flag a pattern fill set up narrower than two pixels; the
      // block does not refuse it, software owns that check
      // the flag is only a hint, shown on the status register
      next_cur.narrow = next_cur.pattern
                      && (next_cur.width < `MIN_PATTERN_WIDTH);
   end

   // the single state register; frozen while the enable is low.
   // the enable also holds read data, so a read strobe under a low
   // enable is lost; the release stages are not gated and always run
   always_ff @(posedge clock or negedge sync_n) begin
      if (!sync_n) begin
         cur.src       <= `RST_ADDR;
         cur.dest      <= `RST_ADDR;
         cur.line_ofs  <= `RST_LINE_OFS;
         cur.width     <= `RST_WIDTH;
         cur.depth     <= depth_8;
         cur.pattern   <= 1'b0;
         cur.rect      <= 1'b0;
         cur.rdata     <= `RST_BYTE;
         cur.line_addr <= `RST_ADDR;
         cur.eff_ofs   <= `RST_LINE_OFS;
         cur.pat_base  <= `RST_ADDR;
         cur.pat_line  <= 3'h0;
         cur.pix_ofs   <= 4'h0;
         cur.pat_sum   <= `RST_ADDR;
         // width field zero with pattern off: not narrow yet
         cur.narrow    <= 1'b0;
      end else if (ce) begin
         cur <= next_cur;
      end
   end

   // outputs straight from the state register; no gate sits between
   // a flop and a pin, so the datapath outside sees clean edges
   assign reg_rdata         = cur.rdata;
   assign dest_start_addr   = cur.dest;
   assign line_offset       = cur.eff_ofs;
   assign transfer_width    = cur.width;
   assign depth_16          = cur.depth;
   assign pattern_fill      = cur.pattern;
   assign rect_region       = cur.rect;
   assign source_start_addr = cur.src;
   assign pattern_base      = cur.pat_base;
   assign pattern_line      = cur.pat_line;
   assign pixel_offset      = cur.pix_ofs;
   assign pattern_src_addr  = cur.pat_sum;
   assign line_addr         = cur.line_addr;
   assign width_too_narrow  = cur.narrow;

endmodule

`default_nettype wire

// file: blit_geometry_address_regs_checker.sv
/*
   port checks for the blit geometry register bank.
   assumes: cfg header and package compiled first; bound to the top.
*/
`timescale 1ns/1ps
`default_nettype none
`include "blit_geom_cfg.svh"

module blit_geometry_address_regs_checker
   import blit_geom_pkg::*;
#(
   parameter int ADDR_W = `REG_ADDR_W, // register address width
   parameter int DATA_W = `REG_DATA_W  // register data width
) (
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              ce,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              line_load,
   input wire logic              line_advance,
   input wire logic [20:0]       dest_start_addr,
   input wire logic [10:0]       line_offset,
   input wire logic [9:0]        transfer_width,
   input wire logic              depth_16,
   input wire logic              rect_region,
   input wire logic [20:0]       source_start_addr,
   input wire logic [20:0]       pattern_base,
   input wire logic [2:0]        pattern_line,
   input wire logic [3:0]        pixel_offset,
   input wire logic [20:0]       pattern_src_addr,
   input wire logic [20:0]       line_addr
);
   // a write the bank really takes; ce low ignores it
   logic wr_ok;
   assign wr_ok = reg_wr && ce;

   // one domain, raw reset as the guard
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   dest_low_a: assert property (wr_ok && reg_addr == 9'h108 |=>
      dest_start_addr[7:0] == $past(reg_wdata)) else $error("dest low");
   dest_top_a: assert property (wr_ok && reg_addr == 9'h10a |=>
      dest_start_addr[20:16] == $past(reg_wdata[4:0])) else $error("dest top");
   width_top_a: assert property (wr_ok && reg_addr == 9'h111 |=>
      transfer_width[9:8] == $past(reg_wdata[1:0])) else $error("width top");
   ofs_gate_a: assert property (!rect_region |->
      line_offset == 11'h000) else $error("offset outside rect mode");
   line_step_a: assert property (line_advance && !line_load && ce |=>
      line_addr == $past(line_addr) + $past(line_offset))
      else $error("line step");
   split_low_a: assert property (!depth_16 |->
      pattern_base == {source_start_addr[20:6], 6'h00}
      && pattern_line == source_start_addr[5:3]
      && pixel_offset == {1'b0, source_start_addr[2:0]})
      else $error("split at 8 bpp");
   split_high_a: assert property (depth_16 |->
      pattern_base == {source_start_addr[20:7], 7'h00}
      && pattern_line == source_start_addr[6:4]
      && pixel_offset == source_start_addr[3:0])
      else $error("split at 16 bpp");
   sum_match_a: assert property (pattern_src_addr == source_start_addr)
      else $error("recombined source differs");
   depth_sel_a: assert property (wr_ok && reg_addr == 9'h101 |=>
      depth_16 == $past(reg_wdata[0])) else $error("depth select");
   ofs_unused_a: assert property (
      reg_rd && ce && reg_addr == 9'h10d |=>
      reg_rdata[7:3] == 5'h00) else $error("offset top bits");

   // main scenarios reached
   cover property (wr_ok && reg_addr == 9'h10a);
   cover property (line_advance && rect_region);
   cover property (depth_16 && reg_rd);
endmodule

bind blit_geometry_address_regs blit_geometry_address_regs_checker #(
   .ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_blit_geometry_address_regs_checker (
   .clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .line_load(line_load),
   .line_advance(line_advance), .dest_start_addr(dest_start_addr),
   .line_offset(line_offset), .transfer_width(transfer_width),
   .depth_16(depth_16), .rect_region(rect_region),
   .source_start_addr(source_start_addr), .pattern_base(pattern_base),
   .pattern_line(pattern_line), .pixel_offset(pixel_offset),
   .pattern_src_addr(pattern_src_addr), .line_addr(line_addr));
`default_nettype wire

// file: blit_geometry_address_regs_test.sv
/*
   self-checking bench for the blit geometry register bank.
   assumes: design, package and checker compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module blit_geometry_address_regs_test
   import blit_geom_pkg::*;
;
   logic        clock, rst_n, ce;           // clock, reset, enable
   logic [8:0]  reg_addr;                   // register offset
   logic [7:0]  reg_wdata, reg_rdata;       // register data
   logic        reg_wr, reg_rd;             // strobes
   logic        line_load, line_advance;    // line stepper pulses
   logic [20:0] dest, src, base, laddr, psum; // address outputs
   logic [10:0] lofs;                       // applied offset
   logic [9:0]  width;                      // width field
   logic        d16, pat, rect, narrow;     // mode outputs
   logic [2:0]  pline;                      // pattern line
   logic [3:0]  pix;                        // pixel offset
   int          fail_count, check_count, cycles; // bookkeeping
   logic [20:0] s;                          // source under test
   // offsets and their implemented bits
   logic [8:0]  ofs [7] = '{9'h108, 9'h109, 9'h10a, 9'h10c, 9'h10d,
                            9'h110, 9'h111};
   logic [7:0]  msk [7] = '{8'hff, 8'hff, 8'h1f, 8'hff, 8'h07, 8'hff,
                            8'h03};

   blit_geometry_address_regs i_blit_geometry_address_regs (
      .clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .line_load(line_load),
      .line_advance(line_advance), .dest_start_addr(dest),
      .line_offset(lofs), .transfer_width(width), .depth_16(d16),
      .pattern_fill(pat), .rect_region(rect), .source_start_addr(src),
      .pattern_base(base), .pattern_line(pline), .pixel_offset(pix),
      .pattern_src_addr(psum), .line_addr(laddr),
      .width_too_narrow(narrow));

   // 250 mhz
   always #2 clock = ~clock;

   // compare seen against expected, four-state
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle write; #1 lets the taking edge land
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask

   // one-cycle read; data stands one cycle, then reads zero
   task automatic rd(input logic [8:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, e);
      @(posedge clock);
      #1 check(reg_rdata, 8'h00);
   endtask

   // one pulse of load, advance or both
   task automatic step(input logic load, input logic adv);
      @(posedge clock);
      line_load <= load;
      line_advance <= adv;
      @(posedge clock);
      line_load <= 1'b0;
      line_advance <= 1'b0;
      #1;
   endtask

   // single exit of the run
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // watchdog; the run needs under 150 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         conclude();
      end
   end

   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd, line_load, line_advance} = '0;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      // reset contents read zero
      foreach (ofs[i]) rd(ofs[i], 8'h00);
      check(dest, 21'h0);
      $display("test reset done");
      // all ones: unused bits drop, unmapped place ignored
      foreach (ofs[i]) wr(ofs[i], 8'hff);
      wr(9'h10b, 8'hff);
      foreach (ofs[i]) rd(ofs[i], msk[i]);
      rd(9'h10b, 8'h00);
      check(dest, 21'h1fffff);
      check(width, 10'h3ff);
      check({rect, lofs}, 12'h000);
      $display("test register map done");
      // offset idle outside rect mode, then wraps the address
      step(1'b1, 1'b0);
      step(1'b0, 1'b1);
      check(laddr, 21'h1fffff);
      wr(9'h11c, 8'h02);
      check({rect, lofs}, 12'hfff);
      step(1'b0, 1'b1);
      step(1'b0, 1'b1);
      check(laddr, 21'h000ffd);
      // load wins over an advance in the same cycle
      step(1'b1, 1'b1);
      check(laddr, 21'h1fffff);
      wr(9'h11e, 8'hff);
      rd(9'h11e, 8'h02);
      $display("test line stepping done");
      // source split at both depths
      s = 21'h15a5a5;
      wr(9'h104, s[7:0]);
      wr(9'h105, s[15:8]);
      wr(9'h106, {3'b111, s[20:16]});
      check(src, s);
      for (int d = 0; d < 2; d++) begin
         wr(9'h101, 8'hfe | d[7:0]);
         rd(9'h101, d[7:0]);
         check(d16, d[0]);
         check(base, d ? {s[20:7], 7'h00} : {s[20:6], 6'h00});
         check(pline, d ? s[6:4] : s[5:3]);
         check(pix, d ? s[3:0] : {1'b0, s[2:0]});
         check(psum, s);
      end
      $display("test pattern split done");
      // narrow width flagged for pattern fill
      wr(9'h11c, 8'h03);
      wr(9'h111, 8'h00);
      wr(9'h110, 8'h00);
      check({pat, narrow}, 2'b11);
      rd(9'h11e, 8'h03);
      wr(9'h110, 8'h01);
      check(narrow, 1'b0);
      $display("test narrow width done");
      // clock enable low freezes the bank, stepper included
      @(posedge clock);
      ce <= 1'b0;
      wr(9'h108, 8'h00);
      step(1'b0, 1'b1);
      @(posedge clock);
      ce <= 1'b1;
      #1 check(dest[7:0], 8'hff);
      check(laddr, 21'h1fffff);
      $display("test enable done");
      conclude();
   end
endmodule
`default_nettype wire
